/* File: design/msf_pkg.sv */
// Purpose: Shared constants, register map and status carriers for the MAC
//          statistics counter bank and unicast filter registers.
// Assumes: 32-bit APB with word-aligned byte addresses.
// Notes:   Counter index i sits at byte address STAT_BASE + 4 * i.
package msf_pkg;

    // Register map, byte addresses.
    localparam int             APB_AW        = 8;
    localparam logic [7:0]     OFF_HASH_HIGH = 8'h00;
    localparam logic [7:0]     OFF_STAT_CTRL = 8'h04;
    localparam logic [7:0]     OFF_SA_BASE   = 8'h08;
    localparam logic [7:0]     OFF_STAT_BASE = 8'h40;
    localparam int             SA_WORDS      = 8;
    localparam int             SA_IDX_W      = 3;
    localparam int             SA_HIGH_W     = 16;
    localparam int             NUM_CNT       = 18;
    localparam int             CNT_IDX_W     = 5;

    // Reset values.
    localparam logic [31:0]    RST_HASH_HIGH = 32'h0000_0000;
    localparam logic [31:0]    RST_SA        = 32'h0000_0000;
    localparam logic [31:0]    RST_STAT_CTRL = 32'h0000_0001;
    localparam int             CTRL_EN_BIT   = 0;

    // Frame length and collision limits.
    localparam logic [10:0]    LEN_MIN       = 11'h040;
    localparam logic [10:0]    LEN_MIN_MULTI = 11'h03e;
    localparam logic [10:0]    LEN_MAX       = 11'h5ee;
    localparam logic [4:0]     COL_ONE       = 5'h01;
    localparam logic [4:0]     COL_TWO       = 5'h02;
    localparam logic [4:0]     COL_MULTI_MAX = 5'h0f;
    localparam logic [4:0]     COL_ABANDON   = 5'h10;

    // Counter indices; the address order follows this list.
    localparam int CNT_TX_OK    = 0;
    localparam int CNT_SCOL     = 1;
    localparam int CNT_MCOL     = 2;
    localparam int CNT_RX_OK    = 3;
    localparam int CNT_FCS      = 4;
    localparam int CNT_ALIGN    = 5;
    localparam int CNT_DEFER    = 6;
    localparam int CNT_LATE     = 7;
    localparam int CNT_EXCESS   = 8;
    localparam int CNT_UNDERRUN = 9;
    localparam int CNT_CARRIER  = 10;
    localparam int CNT_DISCARD  = 11;
    localparam int CNT_OVERRUN  = 12;
    localparam int CNT_CODE     = 13;
    localparam int CNT_LONG     = 14;
    localparam int CNT_JABBER   = 15;
    localparam int CNT_SHORT    = 16;
    localparam int CNT_SQE      = 17;

    localparam int CNT_W [NUM_CNT] = '{24, 16, 16, 24, 8, 8, 16, 8, 8,
                                       8, 8, 16, 8, 8, 8, 8, 8, 8};

    // One-cycle frame report from the transmit engine.
    typedef struct packed {
        logic        done;
        logic        sent_ok;
        logic [4:0]  collisions;
        logic        underrun;
        logic        carrier_lost;
        logic        deferred;
        logic        late_col;
        logic        half_duplex;
        logic        carrier_seen;
        logic        sqe_missing;
        logic [10:0] length;
    } msf_tx_status_s;

    // One-cycle frame report from the receive engine.
    typedef struct packed {
        logic        done;
        logic        addr_match;
        logic        dribble;
        logic        crc_bad;
        logic        code_err;
        logic        no_buffer;
        logic        overrun;
        logic [10:0] length;
    } msf_rx_status_s;

endpackage

/* File: design/msf_sat_cnt.sv */
// Purpose: Saturating statistics counter with clear-on-read.
// Assumes: inc_i and clr_i come from logic on the same clock.
// Notes:   Value is zero-extended to 32 bits for the read mux.
`timescale 1ns/10ps
`default_nettype none
module msf_sat_cnt #(
    parameter int WIDTH = 8
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        inc_i,
    input  wire logic        clr_i,
    output logic      [31:0] value_o
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;
    logic             full;

    // A count landing on the clear cycle survives as one, not lost.
    assign full  = &cnt_q;
    assign cnt_d = clr_i ? {{(WIDTH-1){1'b0}}, inc_i} :
                   (inc_i && !full) ? cnt_q + 1'b1 : cnt_q;
    assign value_o = {{(32-WIDTH){1'b0}}, cnt_q};

    // Counter register; saturation is handled in cnt_d.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end
endmodule
`default_nettype wire

/* File: design/msf_addr_mem.sv */
// Purpose: Eight-word store for the four unicast station addresses.
// Assumes: One write port and one read port on the same clock.
// Notes:   Read data is registered, one cycle after the address.
`timescale 1ns/10ps
`default_nettype none
module msf_addr_mem #(
    parameter int DEPTH = msf_pkg::SA_WORDS,
    parameter int AW    = msf_pkg::SA_IDX_W
) (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [31:0]   wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [31:0]   rdata_o
);
    logic [31:0] mem_q [DEPTH];
    logic [31:0] rdata_q;

    assign rdata_o = rdata_q;

    // Words reset to a known address so an early match cannot misfire.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_q[i] <= msf_pkg::RST_SA;
            rdata_q <= '0;
        end
        else
        begin
            if (we_i)
                mem_q[waddr_i] <= wdata_i;
            rdata_q <= mem_q[raddr_i];
        end
    end
endmodule
`default_nettype wire

/* File: design/msf_top.sv */
// Purpose: Statistics counter bank and unicast address registers of a
//          10/100 MAC, reached over APB.
// Assumes: Frame reports arrive as one-cycle pulses on CLOCK_I from the
//          transmit and receive engines; no synchronisers are needed.
// Notes:   Every read answers with PREADY on the second access cycle.
//Contract
//- Counters clear when software reads them.
//- Counters saturate at all ones, never wrap.
//- 24-bit count of frames sent OK.
//- 16-bit count of single-collision sent frames.
//- 16-bit count of two-to-fifteen-collision frames.
//- 24-bit count of good received frames.
//- 8-bit count of whole-byte bad-CRC frames.
//- 8-bit count of alignment error frames.
//- 16-bit count of first-attempt deferred frames.
//- 8-bit late collision count, also a collision.
//- 8-bit count of frames abandoned after sixteen.
//- 8-bit underrun count, exclusive of all others.
//- 8-bit count of carrier sense errors.
//- 16-bit count of no-buffer discarded frames.
//- 8-bit count of receive overrun frames.
//- 8-bit code error count, exclusive of others.
//- Two 8-bit oversize counters, clean and errored.
//- 8-bit count of clean undersize frames.
//- 8-bit count of missing collision-test frames.
//- Four address-high registers, bits 47:32 low.
//- Four address-low registers, bits 31:0.
//- Register holds hash filter bits 63:32.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module msf_top (
    input  wire logic                    CLOCK_I,
    input  wire logic                    RST_N_I,
    input  wire logic                    PSEL_I,
    input  wire logic                    PENABLE_I,
    input  wire logic                    PWRITE_I,
    input  wire logic [7:0]              PADDR_I,
    input  wire logic [31:0]             PWDATA_I,
    input  wire msf_pkg::msf_tx_status_s TX_STATUS_I,
    input  wire msf_pkg::msf_rx_status_s RX_STATUS_I,
    output logic                         PREADY_O,
    output logic      [31:0]             PRDATA_O,
    output logic                         PSLVERR_O,
    output logic      [31:0]             HASH_HIGH_O
);

    // Length window test, shared by the transmit and receive sorters.
    function automatic logic len_in(input logic [10:0] len,
                                    input logic [10:0] lo,
                                    input logic [10:0] hi);
        len_in = (len >= lo) && (len <= hi);
    endfunction

    // Word offset from a block base, used for both word arrays.
    function automatic logic [5:0] word_of(input logic [7:0] addr,
                                           input logic [7:0] base);
        logic [7:0] diff;
        diff    = addr - base;
        word_of = diff[7:2];
    endfunction

    logic        pready_q;
    logic        pready_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        pslverr_q;
    logic        pslverr_d;
    logic [31:0] hash_high_q;
    logic [31:0] hash_high_d;
    logic [31:0] stat_ctrl_q;
    logic [31:0] stat_ctrl_d;

    // APB phase decode.
    wire         access_first = PSEL_I && PENABLE_I && !pready_q;
    wire         access_done  = PSEL_I && PENABLE_I && pready_q;
    wire         rd_latch     = access_first && !PWRITE_I;
    wire         wr_commit    = access_done && PWRITE_I;
    wire         aligned      = (PADDR_I[1:0] == 2'h0);

    // Address decode into the four regions of the map.
    wire [5:0]   sa_word   = word_of(PADDR_I, msf_pkg::OFF_SA_BASE);
    wire [5:0]   cnt_word  = word_of(PADDR_I, msf_pkg::OFF_STAT_BASE);
    wire         hit_hash  = aligned && (PADDR_I == msf_pkg::OFF_HASH_HIGH);
    wire         hit_ctrl  = aligned && (PADDR_I == msf_pkg::OFF_STAT_CTRL);
    wire         hit_sa    = aligned &&
                             (PADDR_I >= msf_pkg::OFF_SA_BASE) &&
                             (sa_word < 6'(msf_pkg::SA_WORDS));
    wire         hit_cnt   = aligned &&
                             (PADDR_I >= msf_pkg::OFF_STAT_BASE) &&
                             (cnt_word < 6'(msf_pkg::NUM_CNT));
    wire         hit_any   = hit_hash || hit_ctrl || hit_sa || hit_cnt;
    wire [msf_pkg::SA_IDX_W-1:0] sa_idx = sa_word[msf_pkg::SA_IDX_W-1:0];
    wire [msf_pkg::CNT_IDX_W-1:0] cnt_idx =
                             cnt_word[msf_pkg::CNT_IDX_W-1:0];

    // Odd words are the high halves; their upper bits are not stored.
    wire         sa_is_high = sa_idx[0];
    wire [31:0]  sa_wdata   = sa_is_high ?
                              {16'h0000, PWDATA_I[msf_pkg::SA_HIGH_W-1:0]}
                              : PWDATA_I;
    wire         sa_we      = wr_commit && hit_sa;
    logic [31:0] sa_rdata;

    msf_addr_mem #(
        .DEPTH (msf_pkg::SA_WORDS),
        .AW    (msf_pkg::SA_IDX_W)
    ) u_addr_mem (
        .clk_i   (CLOCK_I),
        .rst_n_i (RST_N_I),
        .we_i    (sa_we),
        .waddr_i (sa_idx),
        .wdata_i (sa_wdata),
        .raddr_i (sa_idx),
        .rdata_o (sa_rdata)
    );

    // Counting can be paused by software; reads still clear.
    wire         cnt_en = stat_ctrl_q[msf_pkg::CTRL_EN_BIT];
    wire         tx_go  = TX_STATUS_I.done && cnt_en;
    wire         rx_go  = RX_STATUS_I.done && cnt_en;

    // Transmit frame sorting. An underrun frame goes nowhere else.
    wire         tx_under = tx_go && TX_STATUS_I.underrun;
    wire         tx_rest  = tx_go && !TX_STATUS_I.underrun;
    wire         tx_clean = tx_rest && !TX_STATUS_I.carrier_lost;
    wire [4:0]   tx_cols  = TX_STATUS_I.collisions;
    wire [10:0]  tx_len   = TX_STATUS_I.length;

    wire         ev_tx_ok = tx_rest && TX_STATUS_I.sent_ok;
    wire         ev_scol  = tx_clean && TX_STATUS_I.sent_ok &&
                            (tx_cols == msf_pkg::COL_ONE);
    wire         ev_mcol  = tx_clean && TX_STATUS_I.sent_ok &&
                            (tx_cols >= msf_pkg::COL_TWO) &&
                            (tx_cols <= msf_pkg::COL_MULTI_MAX) &&
                            len_in(tx_len, msf_pkg::LEN_MIN_MULTI,
                                   msf_pkg::LEN_MAX);
    wire         ev_defer = tx_rest && TX_STATUS_I.deferred &&
                            (tx_cols == 5'h00);
    // The late frame also lands in its collision bucket above.
    wire         ev_late  = tx_clean && TX_STATUS_I.late_col;
    wire         ev_exces = tx_clean && !TX_STATUS_I.sent_ok &&
                            (tx_cols == msf_pkg::COL_ABANDON) &&
                            len_in(tx_len, msf_pkg::LEN_MIN,
                                   msf_pkg::LEN_MAX);
    wire         ev_csens = tx_rest && TX_STATUS_I.half_duplex &&
                            !TX_STATUS_I.carrier_seen &&
                            (tx_cols != msf_pkg::COL_ABANDON);
    wire         ev_sqe   = tx_rest && TX_STATUS_I.sqe_missing;

    // Receive frame sorting. A matched code-error frame goes nowhere else.
    wire         rx_match = rx_go && RX_STATUS_I.addr_match;
    wire         ev_code  = rx_match && RX_STATUS_I.code_err;
    wire         rx_rest  = rx_go &&
                            !(RX_STATUS_I.addr_match &&
                              RX_STATUS_I.code_err);
    wire         rx_err   = RX_STATUS_I.crc_bad || RX_STATUS_I.dribble ||
                            RX_STATUS_I.code_err;
    wire [10:0]  rx_len   = RX_STATUS_I.length;
    wire         rx_norm  = len_in(rx_len, msf_pkg::LEN_MIN,
                                   msf_pkg::LEN_MAX);
    wire         rx_mrest = rx_rest && RX_STATUS_I.addr_match;

    wire         ev_rx_ok = rx_mrest && rx_norm && !rx_err;
    wire         ev_fcs   = rx_mrest && rx_norm && !RX_STATUS_I.dribble &&
                            RX_STATUS_I.crc_bad;
    wire         ev_align = rx_mrest && rx_norm && RX_STATUS_I.dribble &&
                            RX_STATUS_I.crc_bad;
    wire         ev_disc  = rx_mrest && RX_STATUS_I.no_buffer;
    wire         ev_ovr   = rx_mrest && RX_STATUS_I.overrun;
    wire         ev_long  = rx_rest && (rx_len > msf_pkg::LEN_MAX) &&
                            !rx_err;
    wire         ev_jab   = rx_rest && (rx_len > msf_pkg::LEN_MAX) &&
                            rx_err;
    wire         ev_short = rx_rest && (rx_len < msf_pkg::LEN_MIN) &&
                            !rx_err;

    // Event vector in counter index order.
    logic [msf_pkg::NUM_CNT-1:0] cnt_inc;
    logic [msf_pkg::NUM_CNT-1:0] cnt_clr;
    logic [31:0]                 cnt_val [msf_pkg::NUM_CNT];

    always_comb
    begin
        cnt_inc                         = '0;
        cnt_inc[msf_pkg::CNT_TX_OK]    = ev_tx_ok;
        cnt_inc[msf_pkg::CNT_SCOL]     = ev_scol;
        cnt_inc[msf_pkg::CNT_MCOL]     = ev_mcol;
        cnt_inc[msf_pkg::CNT_RX_OK]    = ev_rx_ok;
        cnt_inc[msf_pkg::CNT_FCS]      = ev_fcs;
        cnt_inc[msf_pkg::CNT_ALIGN]    = ev_align;
        cnt_inc[msf_pkg::CNT_DEFER]    = ev_defer;
        cnt_inc[msf_pkg::CNT_LATE]     = ev_late;
        cnt_inc[msf_pkg::CNT_EXCESS]   = ev_exces;
        cnt_inc[msf_pkg::CNT_UNDERRUN] = tx_under;
        cnt_inc[msf_pkg::CNT_CARRIER]  = ev_csens;
        cnt_inc[msf_pkg::CNT_DISCARD]  = ev_disc;
        cnt_inc[msf_pkg::CNT_OVERRUN]  = ev_ovr;
        cnt_inc[msf_pkg::CNT_CODE]     = ev_code;
        cnt_inc[msf_pkg::CNT_LONG]     = ev_long;
        cnt_inc[msf_pkg::CNT_JABBER]   = ev_jab;
        cnt_inc[msf_pkg::CNT_SHORT]    = ev_short;
        cnt_inc[msf_pkg::CNT_SQE]      = ev_sqe;
    end

    // The clear lands on the same edge that captures the read data, so
    // no count can slip in between the capture and the clear.
    always_comb
    begin
        cnt_clr = '0;
        if (rd_latch && hit_cnt)
            cnt_clr[cnt_idx] = 1'b1;
    end

    // One counter per statistic, widths from the package table.
    for (genvar g = 0; g < msf_pkg::NUM_CNT; g++)
    begin : g_cnt
        msf_sat_cnt #(
            .WIDTH (msf_pkg::CNT_W[g])
        ) u_cnt (
            .clk_i   (CLOCK_I),
            .rst_n_i (RST_N_I),
            .inc_i   (cnt_inc[g]),
            .clr_i   (cnt_clr[g]),
            .value_o (cnt_val[g])
        );
    end

    // Read mux; the address store answers one cycle after setup.
    wire [31:0]  rd_mux = hit_hash ? hash_high_q :
                          hit_ctrl ? stat_ctrl_q :
                          hit_sa   ? sa_rdata    :
                          hit_cnt  ? cnt_val[cnt_idx] : 32'h0000_0000;

    // Software-visible registers take writes only on the completing edge.
    assign hash_high_d = (wr_commit && hit_hash) ? PWDATA_I
                                                 : hash_high_q;
    assign stat_ctrl_d = (wr_commit && hit_ctrl) ?
                         {31'h0000_0000, PWDATA_I[msf_pkg::CTRL_EN_BIT]}
                         : stat_ctrl_q;

    // Answer timing: one wait cycle, then ready for exactly one cycle.
    assign pready_d  = access_first;
    assign prdata_d  = rd_latch ? rd_mux : prdata_q;
    assign pslverr_d = access_first ? !hit_any : 1'b0;

    // Bus answer and register state.
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            pready_q    <= 1'b0;
            prdata_q    <= 32'h0000_0000;
            pslverr_q   <= 1'b0;
            hash_high_q <= msf_pkg::RST_HASH_HIGH;
            stat_ctrl_q <= msf_pkg::RST_STAT_CTRL;
        end
        else
        begin
            pready_q    <= pready_d;
            prdata_q    <= prdata_d;
            pslverr_q   <= pslverr_d;
            hash_high_q <= hash_high_d;
            stat_ctrl_q <= stat_ctrl_d;
        end
    end

    assign PREADY_O    = pready_q;
    assign PRDATA_O    = prdata_q;
    assign PSLVERR_O   = pslverr_q;
    assign HASH_HIGH_O = hash_high_q;

endmodule
`default_nettype wire

/* File: verification/msf_top_monitor.sv */
// Purpose: Concurrent checks on the register port of msf_top.
// Assumes: One clock domain, active-low asynchronous reset.
// Notes:   Bound into msf_top at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module msf_top_monitor (
    input wire logic        CLOCK_I,
    input wire logic        RST_N_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [7:0]  PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic        PREADY_O,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PSLVERR_O,
    input wire logic [31:0] HASH_HIGH_O
);
    // Counter width per address, so any leak into upper bits shows.
    wire       is_cnt = PADDR_I[1:0] == 2'h0 && PADDR_I >= 8'h40
                        && PADDR_I < 8'h88;
    wire [5:0] cidx   = PADDR_I[7:2] - 6'h10;
    wire [5:0] cw     = is_cnt ? 6'(msf_pkg::CNT_W[cidx[4:0]]) : 6'h0;
    wire       rd_end = PREADY_O && PSEL_I && !PWRITE_I;
    wire       hw_end = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I
                        && PADDR_I == 8'h00;

    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RST_N_I);

    property p_ready_wait;
        PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O;
    endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("ready late");
    property p_ready_pulse;
        PREADY_O |=> !PREADY_O;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready too long");
    property p_ready_cause;
        $rose(PREADY_O) |-> $past(PSEL_I && PENABLE_I) && $past(PSEL_I, 2);
    endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("ready uncaused");
    property p_hash_write;
        hw_end |=> HASH_HIGH_O == $past(PWDATA_I);
    endproperty
    a_hash_write: assert property (p_hash_write)
        else $error("hash write lost");
    property p_hash_hold;
        !$stable(HASH_HIGH_O) |-> $past(hw_end);
    endproperty
    a_hash_hold: assert property (p_hash_hold)
        else $error("hash changed unbidden");
    property p_cnt24;
        rd_end && cw == 6'd24 |-> PRDATA_O[31:24] == 8'h00;
    endproperty
    a_cnt24: assert property (p_cnt24)
        else $error("24-bit counter leak");
    property p_cnt16;
        rd_end && cw == 6'd16 |-> PRDATA_O[31:16] == 16'h0000;
    endproperty
    a_cnt16: assert property (p_cnt16)
        else $error("16-bit counter leak");
    property p_cnt8;
        rd_end && cw == 6'd8 |-> PRDATA_O[31:8] == 24'h000000;
    endproperty
    a_cnt8: assert property (p_cnt8)
        else $error("8-bit counter leak");
    property p_sa_high;
        rd_end && PADDR_I inside {8'h0c, 8'h14, 8'h1c, 8'h24}
            |-> PRDATA_O[31:16] == 16'h0000 && !PSLVERR_O;
    endproperty
    a_sa_high: assert property (p_sa_high)
        else $error("address high leak");
    property p_unaligned;
        PREADY_O && PADDR_I[1:0] != 2'h0
            |-> PSLVERR_O && (PWRITE_I || PRDATA_O == 32'h0);
    endproperty
    a_unaligned: assert property (p_unaligned)
        else $error("unaligned not refused");
endmodule

bind msf_top msf_top_monitor u_monitor (
    .CLOCK_I     (CLOCK_I),
    .RST_N_I     (RST_N_I),
    .PSEL_I      (PSEL_I),
    .PENABLE_I   (PENABLE_I),
    .PWRITE_I    (PWRITE_I),
    .PADDR_I     (PADDR_I),
    .PWDATA_I    (PWDATA_I),
    .PREADY_O    (PREADY_O),
    .PRDATA_O    (PRDATA_O),
    .PSLVERR_O   (PSLVERR_O),
    .HASH_HIGH_O (HASH_HIGH_O)
);
`default_nettype wire

/* File: verification/tb_msf_top.sv */
// Purpose: Self-checking bench for the statistics and address registers.
// Assumes: Status reports are one-cycle pulses in t_sort; t_sat holds one for n cycles to count n.
// Notes:   Each report in t_sort is followed by a read of every counter.
`timescale 1ns/10ps
`default_nettype none
module tb_msf_top;
    logic                    clk;
    logic                    rst_n;
    logic                    psel = 1'b0;
    logic                    penable = 1'b0;
    logic                    pwrite = 1'b0;
    logic [7:0]              paddr = 8'h00;
    logic [31:0]             pwdata = 32'h0;
    msf_pkg::msf_tx_status_s tx_s = '0;
    msf_pkg::msf_rx_status_s rx_s = '0;
    logic                    pready;
    logic [31:0]             prdata;
    logic                    pslverr;
    logic [31:0]             hash;
    logic [31:0]             rd;
    logic                    er;
    int                      num_errors = 0;
    int                      cmp_count = 0;
    int                      cycles = 0;

    msf_top DUT (.CLOCK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .TX_STATUS_I(tx_s), .RX_STATUS_I(rx_s),
        .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr),
        .HASH_HIGH_O(hash));

    // Free-running 125 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Hang guard; the run needs under two thousand cycles.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer from just after an edge, held until ready is high
    // at an edge; the reply is taken at that edge.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
    endtask

    task automatic idle();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                       input logic eexp);
        apb(1'b0, a, 32'h0);
        idle();
        chk(rd, exp);
        chk({31'h0, er}, {31'h0, eexp});
    endtask

    task automatic wrc(input logic [7:0] a, input logic [31:0] d,
                       input logic eexp);
        apb(1'b1, a, d);
        idle();
        chk({31'h0, er}, {31'h0, eexp});
    endtask

    // Flag order f: underrun, carrier lost, deferred, late, half duplex,
    // missing collision test; carrier is seen unless half duplex is set.
    function automatic msf_pkg::msf_tx_status_s txr(input logic ok,
        input logic [4:0] col, input logic [5:0] f, input logic [10:0] len);
        return {1'b1, ok, col, f[5:2], f[1], ~f[1], f[0], len};
    endfunction

    // Flag order f: match, dribble, crc, code, no buffer, overrun.
    function automatic msf_pkg::msf_rx_status_s rxr(input logic [5:0] f,
        input logic [10:0] len);
        return {1'b1, f, len};
    endfunction

    task automatic pulse(input msf_pkg::msf_tx_status_s t,
                         input msf_pkg::msf_rx_status_s r, input int n);
        tx_s <= t;
        rx_s <= r;
        repeat (n) @(posedge clk);
        tx_s <= '0;
        rx_s <= '0;
        @(posedge clk);
    endtask

    // One report, then every counter read: only masked ones show a count.
    task automatic sc(input msf_pkg::msf_tx_status_s t,
                      input msf_pkg::msf_rx_status_s r, input logic [17:0] m);
        pulse(t, r, 1);
        for (int i = 0; i < msf_pkg::NUM_CNT; i++)
            rdc(8'h40 + 8'(4 * i), {31'h0, m[i]}, 1'b0);
    endtask

    task automatic t_reset();
        chk(hash, 32'h0);
        rdc(8'h00, msf_pkg::RST_HASH_HIGH, 1'b0);
        rdc(8'h04, msf_pkg::RST_STAT_CTRL, 1'b0);
        for (int i = 0; i < 8; i++)
            rdc(8'h08 + 8'(4 * i), 32'h0, 1'b0);
        $display("test reset done");
    endtask

    task automatic t_regs();
        wrc(8'h00, 32'ha5c3_0f91, 1'b0);
        chk(hash, 32'ha5c3_0f91);
        rdc(8'h00, 32'ha5c3_0f91, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            wrc(8'h08 + 8'(8 * i), 32'h1234_5670 + i, 1'b0);
            wrc(8'h0c + 8'(8 * i), 32'hdead_be00 + i, 1'b0);
        end
        for (int i = 0; i < 4; i++)
        begin
            rdc(8'h08 + 8'(8 * i), 32'h1234_5670 + i, 1'b0);
            rdc(8'h0c + 8'(8 * i), 32'h0000_be00 + i, 1'b0);
        end
        wrc(8'h40, 32'h0000_0005, 1'b0);
        rdc(8'h40, 32'h0, 1'b0);
        rdc(8'h28, 32'h0, 1'b1);
        rdc(8'h02, 32'h0, 1'b1);
        wrc(8'h01, 32'h0000_0007, 1'b1);
        chk(hash, 32'ha5c3_0f91);
        $display("test registers done");
    endtask

    task automatic t_sort();
        sc(txr(1, 0, 6'h00, 100), rxr(6'h20, 64), 18'h00009);
        sc(txr(1, 1, 6'h00, 100), '0, 18'h00003);
        sc(txr(1, 1, 6'h10, 100), '0, 18'h00001);
        sc(txr(1, 15, 6'h00, 62), '0, 18'h00005);
        sc(txr(1, 2, 6'h00, 61), '0, 18'h00001);
        sc(txr(1, 0, 6'h08, 100), '0, 18'h00041);
        sc(txr(1, 1, 6'h04, 100), '0, 18'h00083);
        sc(txr(0, 16, 6'h00, 64), '0, 18'h00100);
        sc(txr(1, 0, 6'h29, 100), '0, 18'h00200);
        sc(txr(0, 0, 6'h02, 100), '0, 18'h00400);
        sc(txr(1, 0, 6'h01, 100), '0, 18'h20001);
        sc('0, rxr(6'h28, 1518), 18'h00010);
        sc('0, rxr(6'h38, 100), 18'h00020);
        sc('0, rxr(6'h2a, 63), 18'h00800);
        sc('0, rxr(6'h29, 63), 18'h01000);
        sc('0, rxr(6'h2c, 2000), 18'h02000);
        sc('0, rxr(6'h20, 1519), 18'h04000);
        sc('0, rxr(6'h28, 1519), 18'h08000);
        sc('0, rxr(6'h20, 63), 18'h10000);
        $display("test sorting done");
    endtask

    // Undersize counter: saturation, clear, and an event on the clear edge.
    task automatic t_sat();
        pulse('0, rxr(6'h20, 63), 256);
        rdc(8'h80, 32'h0000_00ff, 1'b0);
        rdc(8'h80, 32'h0, 1'b0);
        pulse('0, rxr(6'h20, 63), 3);
        fork
            apb(1'b0, 8'h80, 32'h0);
            begin
                @(posedge clk);
                rx_s <= rxr(6'h20, 63);
                @(posedge clk);
                rx_s <= '0;
            end
        join
        idle();
        chk(rd, 32'h3);
        rdc(8'h80, 32'h1, 1'b0);
        wrc(8'h04, 32'h0, 1'b0);
        pulse('0, rxr(6'h20, 63), 2);
        rdc(8'h80, 32'h0, 1'b0);
        wrc(8'h04, 32'h1, 1'b0);
        $display("test saturation done");
    endtask

    // Reset for six cycles, then each test in turn.
    initial
    begin
        rst_n = 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_regs();
        t_sort();
        t_sat();
        complete_run();
    end
endmodule
`default_nettype wire
